/* File: core/bars_seq.sv */
// autoreclose sequencer top
`timescale 1ns/1ps
`include "bars_regs.svh"
module bars_seq
    import bars_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic tick,
    // initiates and controls (pins)
    input wire logic singlePoleInitiate,
    input wire logic threePoleInitiate,
    input wire logic threePoleDelayedInitiate,
    input wire logic cycleFreezeInput,
    input wire logic schemeInhibitInput,
    input wire logic manualCloseInput,
    input wire logic resetInput,
    // breaker status (pins)
    input wire logic bkr1Closed,
    input wire logic bkr2Closed,
    input wire logic bkr1AnyOpen,
    input wire logic bkr2AnyOpen,
    input wire logic bkr1OutOfService,
    input wire logic bkr2OutOfService,
    // settings
    input wire logic [1:0] recloseProgramSetting,
    input wire logic [1:0] breakerOrderSetting,
    input wire logic [`BARS_SHOT_W-1:0] maxShotsSetting,
    input wire logic closeFailPolicy,
    input wire logic [`BARS_TW-1:0] singlePoleDeadTime,
    input wire logic [`BARS_TW-1:0] threePoleDeadTimeFirst,
    input wire logic [`BARS_TW-1:0] threePoleDeadTimeDelayed,
    input wire logic [`BARS_TW-1:0] resetTime,
    input wire logic [`BARS_TW-1:0] transferTime,
    input wire logic [`BARS_TW-1:0] incompleteTime,
    input wire logic [`BARS_TW-1:0] closeFailTime,
    input wire logic [`BARS_TW-1:0] lockoutReleaseTime,
    input wire logic [`BARS_TW-1:0] forceTripDelay,
    // outputs
    output logic recloseInProgressFlag,
    output logic closeBreakerOneCmd,
    output logic closeBreakerTwoCmd,
    output logic forceThreePoleTrip,
    output logic [`BARS_SHOT_W-1:0] shotCounter,
    output logic lockoutState,
    output logic resetState
);
    // two-stage synchronisers for all pin inputs
    localparam int NIN = 14;
    logic [NIN-1:0] raw, s1_q, s2_q;
    assign raw = {singlePoleInitiate, threePoleInitiate, threePoleDelayedInitiate, cycleFreezeInput,
                  schemeInhibitInput, manualCloseInput, resetInput, bkr1Closed, bkr2Closed,
                  bkr1AnyOpen, bkr2AnyOpen, bkr1OutOfService, bkr2OutOfService, tick};
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    logic spI, tpI, tdI, pause, blk, manCl, rstIn, c1, c2, o1, o2, oos1, oos2, tk;
    assign {spI, tpI, tdI, pause, blk, manCl, rstIn, c1, c2, o1, o2, oos1, oos2, tk} = s2_q;

    logic anyInit;
    assign anyInit = spI | tpI | tdI;

    // sequencer state
    bars_state_t st_q, st_d;
    bars_dt_t dt_q, dt_d;
    logic [`BARS_SHOT_W-1:0] shot_q, shot_d;
    logic rip_q, rip_d, cl1_q, cl1_d, cl2_q, cl2_d;
    logic tpl_q, tpl_d, f3p_q, f3p_d, paused_q, paused_d, second_q, second_d;

    // timers
    logic deadRun, deadDone, rstRun, rstDone, xferRun, xferDone, incRun, incDone;
    logic failRun, failDone, relRun, relDone, spRun, spDone;
    logic [`BARS_TW-1:0] deadLim;
    logic inh1, inh2;

    always_comb begin
        case (dt_q)
            BARS_DT_SP: deadLim = singlePoleDeadTime;
            BARS_DT_3P1: deadLim = threePoleDeadTimeFirst;
            default: deadLim = threePoleDeadTimeDelayed;
        endcase
    end

    assign deadRun = (st_q == BARS_DEAD);
    assign rstRun = (st_q == BARS_WAITRST) && !anyInit && !manCl;
    assign xferRun = (st_q == BARS_XFER) && !anyInit;
    assign incRun = rip_q && (st_q == BARS_DEAD);
    assign failRun = (st_q == BARS_CLOSE);
    assign relRun = (st_q == BARS_LOCK) && (c1 || c2);
    assign spRun = deadRun && (dt_q == BARS_DT_SP);

    bars_timer u_dead (.clock(clock), .sys_rst(sys_rst), .tick(tk), .run(deadRun), .hold(pause),
        .limit(deadLim), .done(deadDone));
    bars_timer u_rst (.clock(clock), .sys_rst(sys_rst), .tick(tk), .run(rstRun), .hold(1'b0),
        .limit(resetTime), .done(rstDone));
    bars_timer u_xfer (.clock(clock), .sys_rst(sys_rst), .tick(tk), .run(xferRun), .hold(1'b0),
        .limit(transferTime), .done(xferDone));
    bars_timer u_inc (.clock(clock), .sys_rst(sys_rst), .tick(tk), .run(incRun), .hold(1'b0),
        .limit(incompleteTime), .done(incDone));
    bars_timer u_fail (.clock(clock), .sys_rst(sys_rst), .tick(tk), .run(failRun), .hold(1'b0),
        .limit(closeFailTime), .done(failDone));
    bars_timer u_rel (.clock(clock), .sys_rst(sys_rst), .tick(tk), .run(relRun), .hold(1'b0),
        .limit(lockoutReleaseTime), .done(relDone));
    bars_timer u_sp (.clock(clock), .sys_rst(sys_rst), .tick(tk), .run(spRun), .hold(1'b0),
        .limit(forceTripDelay), .done(spDone));

    bars_open_watch u_ow1 (.clock(clock), .sys_rst(sys_rst), .anyOpen(o1), .closed(c1),
        .inProgress(rip_q), .inhibit(inh1));
    bars_open_watch u_ow2 (.clock(clock), .sys_rst(sys_rst), .anyOpen(o2), .closed(c2),
        .inProgress(rip_q), .inhibit(inh2));

    // first breaker to close for the chosen order
    function automatic logic firstIsTwo(input logic [1:0] ord);
        firstIsTwo = (ord == `BARS_ORD_TWO) || (ord == `BARS_ORD_21);
    endfunction
    function automatic logic sequential(input logic [1:0] ord);
        sequential = (ord == `BARS_ORD_12) || (ord == `BARS_ORD_21);
    endfunction

    logic firstClosed, secondClosed, goLock;

    // next-state logic; lockout takes priority over everything but reset
    always_comb begin
        st_d = st_q;
        dt_d = dt_q;
        shot_d = shot_q;
        rip_d = rip_q;
        cl1_d = cl1_q;
        cl2_d = cl2_q;
        tpl_d = tpl_q | tpI | tdI;
        f3p_d = f3p_q;
        paused_d = paused_q | pause;
        second_d = second_q;
        goLock = 1'b0;
        firstClosed = firstIsTwo(breakerOrderSetting) ? c2 : c1;
        secondClosed = firstIsTwo(breakerOrderSetting) ? c1 : c2;
        case (st_q)
            BARS_RESET, BARS_WAITRST, BARS_XFER: begin
                if (anyInit) begin
                    if (shot_q == maxShotsSetting) begin
                        goLock = 1'b1;
                    end else if ((tpI || tdI) && shot_q == '0 && (recloseProgramSetting == `BARS_PROG_SINGLE
                            || recloseProgramSetting == `BARS_PROG_3PA)) begin
                        goLock = 1'b1;
                    end else begin
                        st_d = BARS_DEAD;
                        rip_d = 1'b1;
                        paused_d = pause;
                        if (shot_q != '0 || tdI) begin
                            dt_d = BARS_DT_3P2;
                        end else if (tpI || recloseProgramSetting == `BARS_PROG_3PA
                                || recloseProgramSetting == `BARS_PROG_3PB) begin
                            dt_d = BARS_DT_3P1;
                        end else begin
                            dt_d = BARS_DT_SP;
                        end
                    end
                end else if (st_q == BARS_XFER && xferDone) begin
                    st_d = BARS_CLOSE;
                    second_d = 1'b1;
                    if (firstIsTwo(breakerOrderSetting)) cl1_d = 1'b1;
                    else cl2_d = 1'b1;
                end else if (st_q == BARS_WAITRST && rstDone) begin
                    if ((c1 || oos1) && (c2 || oos2)) begin
                        st_d = BARS_RESET;
                        shot_d = '0;
                        f3p_d = 1'b0;
                    end else begin
                        goLock = 1'b1;
                    end
                end
            end
            BARS_DEAD: begin
                if (blk || incDone) begin
                    goLock = 1'b1;
                end else if (paused_q && !pause && dt_q != BARS_DT_3P2) begin
                    dt_d = BARS_DT_3P2;
                end else if (deadDone) begin
                    st_d = BARS_CLOSE;
                    rip_d = 1'b0;
                    tpl_d = 1'b0;
                    shot_d = shot_q + `BARS_SHOT_W'(1);
                    second_d = 1'b0;
                    if (breakerOrderSetting == `BARS_ORD_ONE || breakerOrderSetting == `BARS_ORD_12 ||
                            breakerOrderSetting == `BARS_ORD_21 && 1'b0) cl1_d = !inh1;
                    if (breakerOrderSetting == `BARS_ORD_TWO || breakerOrderSetting == `BARS_ORD_21) cl2_d = !inh2;
                    if (!sequential(breakerOrderSetting) && breakerOrderSetting == `BARS_ORD_ONE) cl2_d = 1'b0;
                end
            end
            BARS_CLOSE: begin
                if (cl1_q && c1) cl1_d = 1'b0;
                if (cl2_q && c2) cl2_d = 1'b0;
                if (!second_q && sequential(breakerOrderSetting) && firstClosed) begin
                    st_d = BARS_XFER;
                end else if ((second_q || !sequential(breakerOrderSetting)) &&
                        ((second_q ? secondClosed : firstClosed))) begin
                    st_d = BARS_WAITRST;
                end else if (failDone || (!cl1_q && !cl2_q)) begin
                    if (sequential(breakerOrderSetting) && !second_q && closeFailPolicy) begin
                        st_d = BARS_XFER;
                        shot_d = shot_q - `BARS_SHOT_W'(1);
                        cl1_d = 1'b0;
                        cl2_d = 1'b0;
                    end else begin
                        goLock = 1'b1;
                    end
                end
            end
            BARS_LOCK: begin
                // a three-pole initiate still standing after lockout must not re-arm the latch
                tpl_d = 1'b0;
                if (manCl || relDone) begin
                    st_d = BARS_RESET;
                    shot_d = '0;
                    f3p_d = 1'b0;
                end
            end
            default: st_d = BARS_RESET;
        endcase
        if (spDone || (shot_d != '0 && st_d != BARS_RESET)) f3p_d = 1'b1;
        if (goLock) begin
            st_d = BARS_LOCK;
            rip_d = 1'b0;
            cl1_d = 1'b0;
            cl2_d = 1'b0;
            tpl_d = 1'b0;
            f3p_d = 1'b0;
        end
        if (rstIn) begin
            st_d = BARS_RESET;
            shot_d = '0;
            rip_d = 1'b0;
            cl1_d = 1'b0;
            cl2_d = 1'b0;
            tpl_d = 1'b0;
            f3p_d = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q <= BARS_RESET;
            dt_q <= BARS_DT_SP;
            shot_q <= '0;
            rip_q <= 1'b0;
            cl1_q <= 1'b0;
            cl2_q <= 1'b0;
            tpl_q <= 1'b0;
            f3p_q <= 1'b0;
            paused_q <= 1'b0;
            second_q <= 1'b0;
        end else begin
            st_q <= st_d;
            dt_q <= dt_d;
            shot_q <= shot_d;
            rip_q <= rip_d;
            cl1_q <= cl1_d;
            cl2_q <= cl2_d;
            tpl_q <= tpl_d;
            f3p_q <= f3p_d;
            paused_q <= paused_d;
            second_q <= second_d;
        end
    end

    // three-pole trip also forced by pause, three-pole programs and nonzero count
    assign forceThreePoleTrip = f3p_q | (pause && rip_q) | (shot_q != '0)
        | (recloseProgramSetting == `BARS_PROG_3PA) | (recloseProgramSetting == `BARS_PROG_3PB)
        | (st_q == BARS_LOCK);
    assign recloseInProgressFlag = rip_q;
    assign closeBreakerOneCmd = cl1_q;
    assign closeBreakerTwoCmd = cl2_q;
    assign shotCounter = shot_q;
    assign lockoutState = (st_q == BARS_LOCK);
    assign resetState = (st_q == BARS_RESET);

    property p_lock_clear;
        @(posedge clock) disable iff (sys_rst) (st_q == BARS_LOCK) |-> !rip_q && !cl1_q && !cl2_q;
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("outputs active in lockout");
    property p_shot_force;
        @(posedge clock) disable iff (sys_rst)
            (shot_q != '0 && st_q != BARS_RESET && st_q != BARS_LOCK) |-> f3p_q;
    endproperty
    a_shot_force: assert property (p_shot_force) else $error("no forced trip with shots");
    property p_max_lock;
        @(posedge clock) disable iff (sys_rst)
            (st_q inside {BARS_RESET, BARS_WAITRST, BARS_XFER} && anyInit && shot_q == maxShotsSetting && !rstIn)
            |=> st_q == BARS_LOCK;
    endproperty
    a_max_lock: assert property (p_max_lock) else $error("max shots did not lock out");
    property p_block_lock;
        @(posedge clock) disable iff (sys_rst) (st_q == BARS_DEAD && blk && !rstIn) |=> st_q == BARS_LOCK;
    endproperty
    a_block_lock: assert property (p_block_lock) else $error("block did not lock out");
    property p_dead_close;
        @(posedge clock) disable iff (sys_rst)
            (st_q == BARS_DEAD && deadDone && !blk && !incDone && !rstIn && !paused_q) |=> st_q == BARS_CLOSE;
    endproperty
    a_dead_close: assert property (p_dead_close) else $error("dead time end did not close");
    property p_reset_clears;
        @(posedge clock) disable iff (sys_rst) rstIn |=> shot_q == '0 && st_q == BARS_RESET;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear");
    property p_rst_stop;
        @(posedge clock) disable iff (sys_rst) (st_q == BARS_WAITRST && anyInit && !rstIn) |=> st_q != BARS_RESET;
    endproperty
    a_rst_stop: assert property (p_rst_stop) else $error("reset timer ran with initiate");
    property p_man_release;
        @(posedge clock) disable iff (sys_rst) (st_q == BARS_LOCK && manCl) |=> st_q == BARS_RESET;
    endproperty
    a_man_release: assert property (p_man_release) else $error("manual close kept lockout");
    property p_tpl_lock;
        @(posedge clock) disable iff (sys_rst) (st_q == BARS_LOCK) |-> !tpl_q;
    endproperty
    a_tpl_lock: assert property (p_tpl_lock) else $error("three-pole latch held in lockout");
endmodule

/* File: core/bars_regs.svh */
// constants of the autoreclose sequencer
// Notes on behaviour
// - initiate enters in-progress, flag latched until close/lockout
// - first shot times single-pole or three-pole dead time
// - dead time end closes breaker per order
// - three-pole initiates latched until close/lockout/reset
// - pause freezes dead timers, resume via delayed
// - pause forces three-pole trip
// - 1.25 cycles into single-pole dead time forces three-pole
// - each reclose counts; nonzero count forces three-pole
// - initiate at max shots gives lockout
// - close starts reset timer; expiry resets, clears count
// - out-of-service breaker ignored; open in-service breaker locks out
// - reset timer stopped by initiate, lockout, manual close
// - order 1-2: transfer timer closes breaker two
// - close failure locks out or continues, decrementing count
// - incomplete-sequence timer expiry before close locks out
// - inhibit input while in progress locks out
// - three-pole initiate on the first shot in the single-pole and 3PA programs locks out
// - lockout held until reset, manual close, ten seconds closed
// - open breaker without in-progress for 30 ms inhibits close
// - shots after the first are three-pole
`ifndef BARS_REGS_SVH
`define BARS_REGS_SVH
`define BARS_TW 16
`define BARS_SHOT_W 3
`define BARS_CLK_NS 5
`define BARS_OPEN_WIN_NS 30000000
`define BARS_OPEN_WIN_CYC (`BARS_OPEN_WIN_NS / `BARS_CLK_NS)
`define BARS_PROG_BOTH 2'h0
`define BARS_PROG_SINGLE 2'h1
`define BARS_PROG_3PA 2'h2
`define BARS_PROG_3PB 2'h3
`define BARS_ORD_ONE 2'h0
`define BARS_ORD_TWO 2'h1
`define BARS_ORD_12 2'h2
`define BARS_ORD_21 2'h3
`endif

/* File: core/bars_pkg.sv */
// types of the autoreclose sequencer
package bars_pkg;
    typedef enum logic [2:0] {
        BARS_RESET = 3'h0,
        BARS_DEAD = 3'h1,
        BARS_CLOSE = 3'h3,
        BARS_XFER = 3'h2,
        BARS_WAITRST = 3'h6,
        BARS_LOCK = 3'h7
    } bars_state_t;
    typedef enum logic [1:0] {
        BARS_DT_SP = 2'h0,
        BARS_DT_3P1 = 2'h1,
        BARS_DT_3P2 = 2'h3
    } bars_dt_t;
endpackage

/* File: core/bars_timer.sv */
// tick-driven timer with programmable terminal count
`timescale 1ns/1ps
`include "bars_regs.svh"
module bars_timer (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // control
    input wire logic tick,
    input wire logic run,
    input wire logic hold,
    input wire logic [`BARS_TW-1:0] limit,
    // status
    output logic done
);
    logic [`BARS_TW-1:0] cnt_q, cnt_d;
    logic done_q, done_d;

    // a stopped timer restarts from zero; hold keeps the count
    always_comb begin
        cnt_d = cnt_q;
        done_d = done_q;
        if (!run) begin
            cnt_d = '0;
            done_d = 1'b0;
        end else if (tick && !hold && !done_q) begin
            if (cnt_q >= limit) begin
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q + `BARS_TW'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done = done_q & run;
endmodule

/* File: core/bars_open_watch.sv */
// breaker open before fault detector
`timescale 1ns/1ps
`include "bars_regs.svh"
module bars_open_watch (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // breaker state
    input wire logic anyOpen,
    input wire logic closed,
    input wire logic inProgress,
    // result
    output logic inhibit
);
    logic [23:0] cnt_q, cnt_d;
    logic inh_q, inh_d;

    // count open time without in-progress; the window is fixed, not tick based
    always_comb begin
        cnt_d = cnt_q;
        inh_d = inh_q;
        if (closed) begin
            inh_d = 1'b0;
            cnt_d = '0;
        end else if (!anyOpen || inProgress) begin
            cnt_d = '0;
        end else if (cnt_q >= 24'(`BARS_OPEN_WIN_CYC)) begin
            inh_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 24'h000001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_q <= '0;
            inh_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            inh_q <= inh_d;
        end
    end

    assign inhibit = inh_q;

    property p_inh_clear;
        @(posedge clock) disable iff (sys_rst) closed |=> !inhibit;
    endproperty
    a_inh_clear: assert property (p_inh_clear) else $error("inhibit kept after close");
endmodule

/* File: tb/bars_bkr_model.sv */
// breaker model: opens on a trip, closes once a close command has stood three cycles
`timescale 1ns/1ps
module bars_bkr_model (
    // clock
    input wire logic clock,
    // trip from bench, close from sequencer
    input wire logic tripReq,
    input wire logic closeCmd,
    // status back to sequencer
    output logic closed,
    output logic anyOpen
);
    logic closedQ = 1'b1;
    logic [1:0] holdCnt = 2'h0;
    // mechanism delay so that a one-cycle command pulse would not close the breaker
    always @(posedge clock) begin
        if (tripReq) begin
            closedQ <= 1'b0;
            holdCnt <= 2'h0;
        end else if (closeCmd && holdCnt != 2'h2) begin
            holdCnt <= holdCnt + 2'h1;
        end else if (closeCmd) begin
            closedQ <= 1'b1;
        end
    end
    assign closed = closedQ;
    assign anyOpen = !closedQ; // no pole discrepancy modelled
endmodule

/* File: tb/tb.sv */
// self-checking bench of the autoreclose sequencer
`timescale 1ns/1ps
`include "bars_regs.svh"
module tb;
    import bars_pkg::*;
    logic clock = 1'b0, sys_rst = 1'b1, tick = 1'b1;
    logic spInit = 1'b0, tpInit = 1'b0, tpdInit = 1'b0, pause = 1'b0, inhibit = 1'b0, manClose = 1'b0;
    logic rstIn = 1'b0, trip1 = 1'b0, trip2 = 1'b0, oos2 = 1'b1, policy = 1'b0;
    logic [1:0] prog = 2'h0, order = 2'h0;
    logic oos1 = 1'b0;
    logic [15:0] incTime = 16'h012C, failTime = 16'h0032, relTime = 16'h0190, f3pDelay = 16'h0002;
    logic [`BARS_SHOT_W-1:0] maxShots = 3'h1;
    logic c1, c2, o1, o2, reclose_in_progress_state, cmd1, cmd2, force3p, lockoutState, resetState;
    logic [`BARS_SHOT_W-1:0] shotCounter;
    int numErrors = 0, nCompared = 0;
    always #2.5 clock = ~clock;
    // tick held high: every cycle is one timer step, keeping expected counts simple
    bars_seq i_bars_seq (.clock(clock), .sys_rst(sys_rst), .tick(tick),
        .singlePoleInitiate(spInit), .threePoleInitiate(tpInit), .threePoleDelayedInitiate(tpdInit),
        .cycleFreezeInput(pause), .schemeInhibitInput(inhibit), .manualCloseInput(manClose),
        .resetInput(rstIn), .bkr1Closed(c1), .bkr2Closed(c2), .bkr1AnyOpen(o1), .bkr2AnyOpen(o2),
        .bkr1OutOfService(oos1), .bkr2OutOfService(oos2), .recloseProgramSetting(prog),
        .breakerOrderSetting(order), .maxShotsSetting(maxShots), .closeFailPolicy(policy),
        .singlePoleDeadTime(16'h0014), .threePoleDeadTimeFirst(16'h001E),
        .threePoleDeadTimeDelayed(16'h0028), .resetTime(16'h003C), .transferTime(16'h000A),
        .incompleteTime(incTime), .closeFailTime(failTime), .lockoutReleaseTime(relTime),
        .forceTripDelay(f3pDelay), .recloseInProgressFlag(reclose_in_progress_state), .closeBreakerOneCmd(cmd1),
        .closeBreakerTwoCmd(cmd2), .forceThreePoleTrip(force3p), .shotCounter(shotCounter),
        .lockoutState(lockoutState), .resetState(resetState));
    bars_bkr_model i_bars_bkr_model (.clock(clock), .tripReq(trip1), .closeCmd(cmd1), .closed(c1), .anyOpen(o1));
    bars_bkr_model i_bars_bkr_model_b (.clock(clock), .tripReq(trip2), .closeCmd(cmd2), .closed(c2), .anyOpen(o2));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            numErrors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic sigOf(input int which);
        case (which)
            0: return cmd1;
            1: return cmd2;
            2: return lockoutState;
            default: return resetState;
        endcase
    endfunction
    // bounded wait for a level; n is the number of cycles it took
    task automatic waitSig(input int which, input logic lvl, output int n);
        n = 0;
        while (sigOf(which) !== lvl && n < 400) begin
            @(negedge clock);
            n++;
        end
        chk(16'(n < 400), 16'h1);
    endtask
    // raise one initiate with the matching trip, checking the in-progress latency
    // expRip is low where the initiate is refused straight into lockout
    task automatic fire(input int kind, input logic expRip);
        @(negedge clock);
        {tpdInit, tpInit, spInit} = 3'h1 << kind;
        trip1 = 1'b1;
        trip2 = !oos2;
        @(negedge clock);
        {trip1, trip2} = 2'h0;
        @(negedge clock);
        chk(reclose_in_progress_state, 1'b0);
        @(negedge clock);
        chk(reclose_in_progress_state, expRip);
        {tpdInit, tpInit, spInit} = 3'h0;
    endtask
    task automatic pulseReset();
        int n;
        rstIn = 1'b1;
        repeat (3) @(negedge clock);
        rstIn = 1'b0;
        waitSig(3, 1'b1, n);
        chk(lockoutState, 1'b0);
    endtask
    task automatic t_single();
        int n;
        fire(0, 1'b1);
        repeat (6) @(negedge clock);
        chk(force3p, 1'b1);
        waitSig(0, 1'b1, n);
        chk(16'(n >= 11 && n <= 20), 16'h1);
        @(negedge clock);
        chk(shotCounter, 3'h1);
        chk(reclose_in_progress_state, 1'b0);
        chk(cmd2, 1'b0);
        waitSig(0, 1'b0, n);
        chk(c1, 1'b1);
        waitSig(3, 1'b1, n);
        chk(shotCounter, 3'h0);
        chk(force3p, 1'b0);
    endtask
    task automatic t_lockmax();
        int n;
        fire(0, 1'b1);
        waitSig(0, 1'b1, n);
        waitSig(0, 1'b0, n);
        chk(force3p, 1'b1);
        fire(0, 1'b0);
        waitSig(2, 1'b1, n);
        chk(n < 8, 1'b1);
        repeat (100) @(negedge clock);
        chk({lockoutState, resetState, cmd1}, 3'h4);
        pulseReset();
    endtask
    task automatic t_prog();
        int n;
        prog = `BARS_PROG_SINGLE;
        fire(1, 1'b0);
        waitSig(2, 1'b1, n);
        chk(cmd1, 1'b0);
        pulseReset();
        prog = `BARS_PROG_BOTH;
        fire(2, 1'b1);
        waitSig(0, 1'b1, n);
        chk(16'(n >= 41 && n <= 44), 16'h1);
        waitSig(3, 1'b1, n);
    endtask
    task automatic t_block();
        int n;
        fire(0, 1'b1);
        inhibit = 1'b1;
        waitSig(2, 1'b1, n);
        chk({reclose_in_progress_state, cmd1, n < 8}, 3'h1);
        inhibit = 1'b0;
        // leave lockout through the manual close path this time
        manClose = 1'b1;
        waitSig(3, 1'b1, n);
        chk({lockoutState, n < 8}, 2'h1);
        manClose = 1'b0;
    endtask
    task automatic t_pause();
        int n;
        fire(0, 1'b1);
        pause = 1'b1;
        // looked at before the single-pole forcing delay has run out, so only pause can raise it
        repeat (2) @(negedge clock);
        chk(force3p, 1'b1);
        repeat (62) @(negedge clock);
        chk(cmd1, 1'b0);
        pause = 1'b0;
        waitSig(0, 1'b1, n);
        chk(16'(n >= 37 && n <= 48), 16'h1);
        waitSig(3, 1'b1, n);
    endtask
    // sequence 1-2 with both breakers in service
    task automatic t_xfer();
        int n;
        oos2 = 1'b0;
        order = `BARS_ORD_12;
        fire(0, 1'b1);
        waitSig(0, 1'b1, n);
        chk(cmd2, 1'b0);
        waitSig(1, 1'b1, n);
        chk(16'(n >= 12 && n <= 25), 16'h1);
        waitSig(3, 1'b1, n);
        chk({c1, c2, shotCounter}, 5'h18);
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clock);
        sys_rst = 1'b0;
        @(negedge clock);
        chk({resetState, reclose_in_progress_state, cmd1, cmd2, shotCounter}, 7'h40);
        t_single();
        t_lockmax();
        t_prog();
        t_block();
        t_pause();
        t_xfer();
        summarize();
    end
    // watchdog well beyond the several hundred cycles that the scenarios need
    initial begin
        #100000;
        numErrors++;
        summarize();
    end
endmodule
